// >>> elapsed_time_meter_block.sv
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module elapsed_time_meter_block
	import hour_meter_pkg::*;
#(
	parameter int INSTANCE = 197,
	parameter int TICK_LEN = TICK_CYCLES,
	parameter int SAVE_LEN = SAVE_SECONDS
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// logic_block pins
	input wire logic run_in,
	input wire logic clear_in,
	output logic meter_out,
	// values for other logic_block instances
	output logic [14:0] set_major,
	output logic [5:0] set_minor,
	output logic [14:0] cur_major,
	output logic [5:0] cur_minor,
	// nonvolatile store port
	output logic nv_write,
	output logic [20:0] nv_wdata,
	input wire logic nv_valid,
	input wire logic [20:0] nv_rdata
);
	// clamp a written field to its legal range
	function automatic logic [5:0] clamp_sub(input logic [31:0] v);
		clamp_sub = (v > 32'(SUB_MAX)) ? SUB_MAX : v[5:0];
	endfunction

	logic unit_ff;
	logic sw_run_ff;
	logic sw_clr_ff;
	logic [14:0] set_hi_ff;
	logic [5:0] set_lo_ff;
	logic [14:0] cur_hi_ff;
	logic [5:0] cur_lo_ff;
	logic out_ff;
	logic [31:0] prdata_ff;
	logic [31:0] save_cnt_ff;
	logic dirty_ff;
	logic nv_write_ff;
	logic restored_ff;
	logic [14:0] nxt_hi;
	logic [5:0] nxt_lo;

	// bus decode; register map, one aligned 32-bit word each:
	//   ctrl    : unit select, software run, software clear, retain flag (read only)
	//   set_hi  : target major field, writes above the top value clamp to the top
	//   set_lo  : target minor field, writes above 59 clamp to 59
	//   cur_hi  : current major field, read only
	//   cur_lo  : current minor field, read only
	//   status  : output level and save-pending flag
	//   nv_hi/lo: reserved for the store, they read as zero and ignore writes
	// flat compares keep the decode one gate level deep at 250 MHz
	wire acc = psel & penable;
	wire wr = acc & pwrite & ce;
	wire rd = acc & ~pwrite & ce;
	wire hit = (paddr == OFS_CTRL) | (paddr == OFS_SET_HI) | (paddr == OFS_SET_LO) |
		(paddr == OFS_CUR_HI) | (paddr == OFS_CUR_LO) | (paddr == OFS_STATUS) |
		(paddr == OFS_NV_HI) | (paddr == OFS_NV_LO);
	wire wr_ctrl = wr & (paddr == OFS_CTRL);
	wire wr_set_hi = wr & (paddr == OFS_SET_HI);
	wire wr_set_lo = wr & (paddr == OFS_SET_LO);
	wire retain = (INSTANCE >= NV_FIRST) && (INSTANCE <= NV_LAST);

	// effective controls: pin or software bit
	// the software bits let a host exercise the meter with the pins idle;
	// a held clear masks run so the tick divider also pauses while clearing
	wire clr = clear_in | sw_clr_ff;
	wire run = (run_in | sw_run_ff) & ~clr;
	wire tick;

	// one-second strobe; the divider keeps its partial count over stops,
	// so short on/off bursts still add up to whole seconds
	// limitation: a clear does not drop the partial second in the divider
	hm_tick_gen #(
		.CYCLES(TICK_LEN)
	) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.run(run),
		.tick(tick)
	);

	// minor field rolls to zero after 59 and carries into major; mm:ss carries sub into minutes
	wire lo_wrap = (cur_lo_ff == SUB_MAX);
	logic [5:0] sec_ff;
	logic [5:0] nxt_sec;
	// in hh:mm mode a seconds prescaler counts to a minute before the minor field moves
	wire sec_wrap = (sec_ff == SUB_MAX);
	wire step = tick & ((unit_ff == UNIT_MMSS) | sec_wrap);
	assign nxt_sec = (tick & (unit_ff == UNIT_HHMM)) ? (sec_wrap ? SUB_RST : sec_ff + 6'h1) : sec_ff;

	// next count: clear first, then a step of the minor field
	// clear is checked before step so a clear held with run keeps zero
	// the minor field wraps at 59 and carries into the major field
	// at the very top the count pins at its largest value instead of wrapping,
	// otherwise the output would drop back off after a long run
	always_comb begin
		nxt_hi = cur_hi_ff;
		nxt_lo = cur_lo_ff;
		if (clr) begin
			nxt_hi = HOUR_RST;
			nxt_lo = SUB_RST;
		end else if (step) begin
			// major field saturates so it never wraps back under the target
			nxt_lo = lo_wrap ? SUB_RST : cur_lo_ff + 6'h1;
			if (lo_wrap && cur_hi_ff != HOUR_MAX) begin
				nxt_hi = cur_hi_ff + 15'h1;
			end else if (lo_wrap) begin
				nxt_lo = SUB_MAX;
			end
		end
	end

	// output compare is combinational on the registered count, then registered
	wire reached = {cur_hi_ff, cur_lo_ff} >= {set_hi_ff, set_lo_ff};

	// count registers
	// in a retain instance the first word offered by the store after reset replaces the count,
	// unless clear is held then: a held clear always wins and the word is dropped
	// the seconds prescaler is only meaningful in hh:mm mode
	// and is zeroed by clear so a cleared meter starts on a whole minute
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_hi_ff <= HOUR_RST;
			cur_lo_ff <= SUB_RST;
			sec_ff <= SUB_RST;
		end else if (ce) begin
			if (!restored_ff && nv_valid && retain && !clr) begin
				cur_hi_ff <= nv_rdata[20:6];
				cur_lo_ff <= nv_rdata[5:0];
			end else begin
				cur_hi_ff <= nxt_hi;
				cur_lo_ff <= nxt_lo;
			end
			sec_ff <= clr ? SUB_RST : nxt_sec;
		end
	end

	// restore happens once, the first time the store offers data
	// later offers are ignored so a chattering store cannot rewind the count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			restored_ff <= 1'b0;
		end else if (ce && nv_valid) begin
			restored_ff <= 1'b1;
		end
	end

	// setup registers written by software
	// out-of-range targets clamp rather than fault, so a careless write
	// still leaves a reachable target behind
	// the write strobe already carries the clock enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_ff <= UNIT_HHMM;
			sw_run_ff <= 1'b0;
			sw_clr_ff <= 1'b0;
			set_hi_ff <= HOUR_RST;
			set_lo_ff <= SUB_RST;
		end else begin
			if (wr_ctrl) begin
				unit_ff <= pwdata[CTRL_UNIT_BIT];
				sw_run_ff <= pwdata[CTRL_RUN_BIT];
				sw_clr_ff <= pwdata[CTRL_CLR_BIT];
			end
			if (wr_set_hi) begin
				set_hi_ff <= pwdata[31:15] != 17'h0 ? HOUR_MAX : pwdata[14:0];
			end
			if (wr_set_lo) begin
				set_lo_ff <= clamp_sub(pwdata);
			end
		end
	end

	// output register
	// the output is a plain compare, so a clear below target turns it off again
	// trade-off: one cycle of lag behind the count for a glitch-free pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_ff <= 1'b0;
		end else if (ce) begin
			out_ff <= reached;
		end
	end

	// save only at a slow period and only if the count changed, to spare write endurance
	// the period counts seconds of running, not wall time, so an idle meter never writes
	// dirty marks a count not yet in the store; a step in the save cycle is
	// folded into that save because the word is taken one cycle later
	// limitation: a power loss loses up to one save period of counting
	wire save_due = (save_cnt_ff == 32'(SAVE_LEN - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			save_cnt_ff <= 32'h0;
			dirty_ff <= 1'b0;
			nv_write_ff <= 1'b0;
		end else if (ce) begin
			nv_write_ff <= 1'b0;
			if (tick) begin
				save_cnt_ff <= save_due ? 32'h0 : save_cnt_ff + 32'h1;
			end
			if (tick && save_due && (dirty_ff || step) && retain) begin
				nv_write_ff <= 1'b1;
				dirty_ff <= 1'b0;
			end else if (step || clr) begin
				dirty_ff <= 1'b1;
			end
		end
	end

	// read data register
	// read data is captured in the setup cycle so the access phase needs no wait
	// unknown and store offsets read as zero
	// frozen with the rest of the state while the clock enable is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0;
		end else if (ce && psel && !penable && !pwrite) begin
			case (paddr)
				OFS_CTRL: prdata_ff <= {28'h0, retain, sw_clr_ff, sw_run_ff, unit_ff};
				OFS_SET_HI: prdata_ff <= {17'h0, set_hi_ff};
				OFS_SET_LO: prdata_ff <= {26'h0, set_lo_ff};
				OFS_CUR_HI: prdata_ff <= {17'h0, cur_hi_ff};
				OFS_CUR_LO: prdata_ff <= {26'h0, cur_lo_ff};
				OFS_STATUS: prdata_ff <= {30'h0, dirty_ff, out_ff};
				default: prdata_ff <= 32'h0;
			endcase
		end
	end

	// apb answer: zero wait states, error on unmapped address
	// read data is forced to zero outside a read access so the shared
	// read bus of a larger map can simply or the slaves together
	assign pready = 1'b1;
	assign pslverr = acc & ~hit;
	assign prdata = rd ? prdata_ff : 32'h0;

	// pins and exported values
	// the major and minor fields mean hours and minutes in hh:mm mode,
	// minutes and seconds in mm:ss mode; the store word is the count as one value
	assign meter_out = out_ff;
	assign set_major = set_hi_ff;
	assign set_minor = set_lo_ff;
	assign cur_major = cur_hi_ff;
	assign cur_minor = cur_lo_ff;
	assign nv_write = nv_write_ff;
	assign nv_wdata = {cur_hi_ff, cur_lo_ff};
endmodule

// >>> elapsed_time_meter_block_test.sv
`timescale 1ns/1ps
module elapsed_time_meter_block_test;
	import hour_meter_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic run_in = 1'b0, clear_in = 1'b0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, meter_out, nv_write, nv_valid;
	logic [14:0] set_major, cur_major;
	logic [5:0] set_minor, cur_minor;
	logic [20:0] nv_wdata, nv_rdata, pre;
	int errors = 0, tests_run = 0, n;
	initial forever #2 pclk = ~pclk;
	// short tick and save counts keep the run brief
	elapsed_time_meter_block #(.INSTANCE(197), .TICK_LEN(4), .SAVE_LEN(3)) DUT (.pclk, .presetn, .ce(1'b1),
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .run_in, .clear_in, .meter_out,
		.set_major, .set_minor, .cur_major, .cur_minor, .nv_write, .nv_wdata, .nv_valid, .nv_rdata);
	nv_store_model nv (.pclk, .presetn, .nv_write, .nv_wdata, .nv_valid, .nv_rdata);
	task automatic check(input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	// one apb transfer; idle cycle after so strobes never change twice in a step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata; err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_cnt(input logic [20:0] v);
		for (n = 0; n < 600 && {cur_major, cur_minor} !== v; n++) @(posedge pclk);
		check(n < 600, 1);
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#40000 errors++;
		summarize();
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(0, OFS_SET_HI, 0); check(rd, 0);
		apb(0, OFS_SET_LO, 0); check(rd, 0);
		apb(1, OFS_SET_HI, 32'h9c40); apb(0, OFS_SET_HI, 0); check(rd, 32'h7fff);
		apb(1, OFS_SET_LO, 32'h46); apb(0, OFS_SET_LO, 0); check(rd, 32'h3b);
		apb(1, 8'h20, 32'h1); check(err, 1);
		apb(1, OFS_CTRL, 32'h1); apb(1, OFS_SET_HI, 0); apb(1, OFS_SET_LO, 32'h3);
		check(set_minor, 3);
		apb(0, OFS_CTRL, 0); check(rd, 32'h9);
		run_in <= 1'b1; wait_cnt(21'h3); repeat (2) @(posedge pclk); check(meter_out, 1);
		wait_cnt(21'h5); check(cur_minor, 5); check(meter_out, 1);
		clear_in <= 1'b1; repeat (12) @(posedge pclk); check(cur_minor, 0); check(meter_out, 0);
		clear_in <= 1'b0; wait_cnt({15'h1, 6'h0}); check({cur_major, cur_minor}, {15'h1, 6'h0});
		run_in <= 1'b0; repeat (8) @(posedge pclk); pre = {cur_major, cur_minor};
		repeat (8) @(posedge pclk); check({cur_major, cur_minor}, pre);
		presetn <= 1'b0; repeat (8) @(posedge pclk);
		presetn <= 1'b1; repeat (8) @(posedge pclk);
		check({cur_major, cur_minor} != 0 && {cur_major, cur_minor} <= pre, 1);
		clear_in <= 1'b1; repeat (2) @(posedge pclk); clear_in <= 1'b0;
		apb(1, OFS_SET_LO, 32'h1);
		run_in <= 1'b1; wait_cnt(21'h1); check(n >= 200, 1);
		repeat (2) @(posedge pclk); apb(0, OFS_STATUS, 0); check(rd[0], 1);
		summarize();
	end
endmodule
bind elapsed_time_meter_block meter_checker chk (.*);

// >>> hm_tick_gen.sv
`timescale 1ns/1ps
// divides the scan clock down to a one-second strobe
module hm_tick_gen
	import hour_meter_pkg::*;
#(
	parameter int CYCLES = TICK_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// control
	input wire logic run,
	output logic tick
);
	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;
	wire last = (cnt_ff == 32'(CYCLES - 1));

	// counter only advances while running, so partial seconds are kept over stops
	assign nxt_cnt = last ? 32'h0 : cnt_ff + 32'h1;
	assign tick = ce & run & last;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 32'h0;
		end else if (ce && run) begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule

// >>> hour_meter_pkg.sv
package hour_meter_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SET_HI = 8'h04;
	localparam logic [7:0] OFS_SET_LO = 8'h08;
	localparam logic [7:0] OFS_CUR_HI = 8'h0c;
	localparam logic [7:0] OFS_CUR_LO = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_NV_HI = 8'h18;
	localparam logic [7:0] OFS_NV_LO = 8'h1c;
	// ctrl fields
	localparam int CTRL_UNIT_BIT = 0;
	localparam int CTRL_RUN_BIT = 1;
	localparam int CTRL_CLR_BIT = 2;
	localparam int CTRL_RETAIN_BIT = 3;
	// status fields
	localparam int STAT_OUT_BIT = 0;
	localparam int STAT_SAVE_BUSY_BIT = 1;
	// field limits and reset values
	localparam logic [14:0] HOUR_MAX = 15'h7fff;
	localparam logic [5:0] SUB_MAX = 6'h3b;
	localparam logic [14:0] HOUR_RST = 15'h0000;
	localparam logic [5:0] SUB_RST = 6'h00;
	// time base: one second at 250 MHz
	localparam int CLK_MHZ = 250;
	localparam int TICK_US = 1000000;
	localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
	// save period: one hour keeps nonvolatile writes well under 10000 per year of heavy use
	localparam int SAVE_SECONDS = 3600;
	localparam int NV_FIRST = 197;
	localparam int NV_LAST = 200;
	// resolution modes
	typedef enum logic {
		UNIT_HHMM = 1'b0,
		UNIT_MMSS = 1'b1
	} unit_t;
endpackage

// >>> meter_checker.sv
`timescale 1ns/1ps
module meter_checker (
	// bus
	input wire logic pclk, presetn, psel, penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready, pslverr,
	// pins and values
	input wire logic run_in, clear_in, meter_out, nv_write, nv_valid,
	input wire logic [14:0] set_major, cur_major,
	input wire logic [5:0] set_minor, cur_minor,
	input wire logic [20:0] nv_wdata
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// count as one word; plain means the run pin high with no clear or restore in the way
	wire [20:0] cnt = {cur_major, cur_minor};
	wire plain = run_in && !clear_in && !nv_valid;
	ready_high_a: assert property (pready) else $error("pready low");
	unmapped_err_a: assert property (psel && penable && paddr > 8'h1c |-> pslverr) else $error("no slave error");
	idle_read_a: assert property (!penable |-> prdata == 32'h0) else $error("read data outside access");
	out_cmp_a: assert property ($past(presetn) |->
		meter_out == ($past(cnt) >= $past({set_major, set_minor}))) else $error("output disagrees with count");
	clear_zero_a: assert property (clear_in |=> cnt == 21'h0) else $error("clear ignored");
	hold_idle_a: assert property (!run_in && !$past(run_in) && !clear_in && !nv_valid |=> $stable(cnt))
		else $error("count moved while idle");
	minor_step_a: assert property ($past(plain) && $past(presetn) && cur_minor != $past(cur_minor) |->
		cur_minor == ($past(cur_minor) == 6'h3b ? 6'h00 : $past(cur_minor) + 6'h01)) else $error("bad minor step");
	major_carry_a: assert property ($past(plain) && $past(presetn) && $past(cur_minor) == 6'h3b &&
		cur_minor == 6'h00 |-> cur_major == $past(cur_major) + 15'h0001) else $error("no carry");
	save_data_a: assert property (nv_write |-> nv_wdata == cnt || nv_wdata == $past(cnt))
		else $error("saved word wrong");
	save_pulse_a: assert property (nv_write |=> !nv_write) else $error("save not a pulse");
endmodule

// >>> nv_store_model.sv
`timescale 1ns/1ps
// store keeps its word through presetn and replays it once after each reset
module nv_store_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic nv_write,
	input wire logic [20:0] nv_wdata,
	output logic nv_valid,
	output logic [20:0] nv_rdata
);
	logic [20:0] mem_ff = 21'h0;
	logic [1:0] dly_ff;
	always @(posedge pclk) if (nv_write) mem_ff <= nv_wdata;
	// short replay delay; the data line is inverted when not valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) dly_ff <= 2'h0;
		else if (dly_ff != 2'h3) dly_ff <= dly_ff + 2'h1;
	end
	assign nv_valid = dly_ff == 2'h2;
	assign nv_rdata = nv_valid ? mem_ff : ~mem_ff;
endmodule
